// *** logic/lamp_check_defines.vh ***
/*
 Constants for the indicator lamp self-check sequencer: timing figures,
 derived cycle counts and lamp counts. Assumes a 20 MHz system clock.
*/
`ifndef LAMP_CHECK_DEFINES_VH
`define LAMP_CHECK_DEFINES_VH

`define CLK_SYS_HZ 20000000
`define TICK_MS_CYCLES (`CLK_SYS_HZ / 1000)
`define LAMP_COUNT 62
`define LAMP_ROWS 6
`define TRIGGER_SEL_W 4
`define TRIGGER_COUNT 16
`define MIN_PULSE_MS 250
`define STAGE1_MAX_MS 60000
`define STEP_MS 1000

`endif

// *** logic/lamp_check_sequencer.v ***
/*
 Indicator lamp self-check sequencer with shadowed normal lamp requests.
 Assumes control operands are synchronous to clk_sys and lamp drivers take
 lamp_out directly; the whole lamp set includes pushbutton lamps.
*/
// What this block does
// - Test starts only when enabled, from the configured control operand
// - Every lamp, pushbutton lamps included, is driven for the whole test
// - Stage one lights all 62 lamps together
// - Stage one lasts only while the control input stays asserted
// - Control held one minute in stage one ends the whole test
// - Stage two: all off, then each lamp alone on for one second
// - Stage two scans from top-left, down each column, then next column
// - Stage three: all on, each lamp alone off for one second
// - Stage three scans in the same order as stage two
// - Stages two and three can be interrupted at any moment
// - During test, lamps follow only the test sequence
// - Normal lamp changes are still accepted; the live request input serves as the store
// - At test end, lamps immediately show their shadowed state
// - Target reset requests are ignored while the test runs
// - Test-active output stands from test start until test end
// - One test-started event is emitted whenever the test begins
// - Level and rising edges of control steer progress and abort
// - Control pulses under 250 ms are ignored
// - Control release in stage one moves to stage two
// - Stage two completing all lamps enters stage three
// - After stage one, a new control press aborts the test
`timescale 1ns/1ps
`include "lamp_check_defines.vh"
module lamp_check_sequencer #(
    parameter LAMPS = `LAMP_COUNT,
    parameter ROWS = `LAMP_ROWS,
    parameter TICK_CYCLES = `TICK_MS_CYCLES,
    parameter MIN_PULSE_MS = `MIN_PULSE_MS,
    parameter STAGE1_MAX_MS = `STAGE1_MAX_MS,
    parameter STEP_MS = `STEP_MS
) (
    input wire clk_sys,
    input wire rst_n,
    input wire lamp_check_enable,
    input wire [`TRIGGER_SEL_W-1:0] lamp_check_trigger_select,
    input wire [`TRIGGER_COUNT-1:0] control_operands,
    input wire [LAMPS-1:0] lamp_request,
    input wire target_reset_request,
    output reg [LAMPS-1:0] lamp_out,
    output reg lamp_check_active_flag,
    output reg lamp_check_begun_event,
    output reg target_reset_out,
    output reg [1:0] stage_out
);
    localparam ST_IDLE = 2'd0;
    localparam ST_ALL_ON = 2'd1;
    localparam ST_WALK_ON = 2'd2;
    localparam ST_WALK_OFF = 2'd3;

    // Lamp index order is column-major: index = column * ROWS + row,
    // so counting upward walks down each column before the next one.
    function [LAMPS-1:0] one_hot;
        input [7:0] idx;
        integer k;
        begin
            one_hot = {LAMPS{1'b0}};
            for (k = 0; k < LAMPS; k = k + 1) begin
                if (idx == k[7:0]) begin
                    one_hot[k] = 1'b1;
                end
            end
        end
    endfunction

    // Stages two and three share the one-second stepping
    function is_scan;
        input [1:0] st;
        begin
            is_scan = (st == ST_WALK_ON) || (st == ST_WALK_OFF);
        end
    endfunction

    // single-lamp pattern, inverted for the dark walk
    function [LAMPS-1:0] walk_pattern;
        input [7:0] idx;
        input dark;
        begin
            if (dark) begin
                walk_pattern = ~one_hot(idx);
            end else begin
                walk_pattern = one_hot(idx);
            end
        end
    endfunction

    wire tick;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [31:0] hold_ms_reg;
    reg ctrl_filt_reg;
    reg ctrl_filt_prev_reg;
    reg [31:0] stage_ms_reg;
    reg [7:0] lamp_idx_reg;
    reg [7:0] lamp_idx_next;
    reg [LAMPS-1:0] lamp_next;
    reg end_test;
    reg advance;
    reg step_done;
    wire in_scan;

    assign in_scan = is_scan(state_reg);

    ms_tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick_reg(tick)
    );

    wire ctrl_raw = control_operands[lamp_check_trigger_select];

    // pulse width count, saturating at the threshold
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hold_ms_reg <= 32'h0000_0000;
        end else if (!ctrl_raw) begin
            hold_ms_reg <= 32'h0000_0000;
        end else if (tick && hold_ms_reg < MIN_PULSE_MS - 1) begin
            hold_ms_reg <= hold_ms_reg + 32'h0000_0001;
        end
    end

    // qualified level; short pulses never reach it.
    // Release drops it at once, so stage two starts without delay.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_filt_reg <= 1'b0;
        end else if (!ctrl_raw) begin
            ctrl_filt_reg <= 1'b0;
        end else if (tick && hold_ms_reg >= MIN_PULSE_MS - 1) begin
            ctrl_filt_reg <= 1'b1;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_filt_prev_reg <= 1'b0;
        end else begin
            ctrl_filt_prev_reg <= ctrl_filt_reg;
        end
    end

    wire ctrl_rise = ctrl_filt_reg & ~ctrl_filt_prev_reg;

    always @* begin
        state_next = state_reg;
        end_test = 1'b0;
        advance = 1'b0;
        step_done = tick && (stage_ms_reg >= STEP_MS - 1);
        case (state_reg)
            ST_IDLE: begin
                if (lamp_check_enable && ctrl_rise) begin
                    state_next = ST_ALL_ON;
                    advance = 1'b1;
                end
            end
            ST_ALL_ON: begin
                if (tick && stage_ms_reg >= STAGE1_MAX_MS - 1) begin
                    state_next = ST_IDLE;
                    end_test = 1'b1;
                end else if (!ctrl_filt_reg) begin
                    state_next = ST_WALK_ON;
                    advance = 1'b1;
                end
            end
            ST_WALK_ON: begin
                if (ctrl_rise) begin
                    state_next = ST_IDLE;
                    end_test = 1'b1;
                end else if (step_done && lamp_idx_reg == LAMPS - 1) begin
                    state_next = ST_WALK_OFF;
                    advance = 1'b1;
                end
            end
            ST_WALK_OFF: begin
                if (ctrl_rise) begin
                    state_next = ST_IDLE;
                    end_test = 1'b1;
                end else if (step_done && lamp_idx_reg == LAMPS - 1) begin
                    state_next = ST_IDLE;
                    end_test = 1'b1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage_ms_reg <= 32'h0000_0000;
        end else if (advance || end_test) begin
            stage_ms_reg <= 32'h0000_0000;
        end else if (in_scan && step_done) begin
            stage_ms_reg <= 32'h0000_0000;
        end else if (state_reg != ST_IDLE && tick) begin
            stage_ms_reg <= stage_ms_reg + 32'h0000_0001;
        end
    end

    // column-major stepping; computed once so the lamp pattern
    // and the scan counter change on the same edge
    always @* begin
        if (advance || end_test) begin
            lamp_idx_next = 8'h00;
        end else if (in_scan && step_done) begin
            lamp_idx_next = lamp_idx_reg + 8'h01;
        end else begin
            lamp_idx_next = lamp_idx_reg;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lamp_idx_reg <= 8'h00;
        end else begin
            lamp_idx_reg <= lamp_idx_next;
        end
    end

    always @* begin
        case (state_next)
            ST_ALL_ON: begin
                lamp_next = {LAMPS{1'b1}};
            end
            ST_WALK_ON: begin
                lamp_next = walk_pattern(lamp_idx_next, 1'b0);
            end
            ST_WALK_OFF: begin
                lamp_next = walk_pattern(lamp_idx_next, 1'b1);
            end
            default: begin
                // requests keep flowing in throughout; the
                // request input itself is the store, so release is immediate
                lamp_next = lamp_request;
            end
        endcase
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lamp_out <= {LAMPS{1'b0}};
        end else begin
            lamp_out <= lamp_next;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lamp_check_active_flag <= 1'b0;
        end else begin
            lamp_check_active_flag <= (state_next != ST_IDLE);
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lamp_check_begun_event <= 1'b0;
        end else begin
            lamp_check_begun_event <= (state_reg == ST_IDLE) &&
                (state_next == ST_ALL_ON);
        end
    end

    // reset blocked, also on the start and end cycles
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            target_reset_out <= 1'b0;
        end else begin
            target_reset_out <= target_reset_request &&
                (state_reg == ST_IDLE) && (state_next == ST_IDLE);
        end
    end

    // Stage report follows the state register
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage_out <= ST_IDLE;
        end else begin
            stage_out <= state_next;
        end
    end
endmodule // lamp_check_sequencer

// *** logic/ms_tick_gen.v ***
/*
 Millisecond tick prescaler: one-cycle pulse every CYCLES system clocks.
 Assumes a free-running system clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
module ms_tick_gen #(
    parameter CYCLES = 20000
) (
    input wire clk_sys,
    input wire rst_n,
    output reg tick_reg
);
    reg [31:0] count_reg;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else if (count_reg == CYCLES - 1) begin
            count_reg <= 32'h0000_0000;
            tick_reg <= 1'b1;
        end else begin
            count_reg <= count_reg + 32'h0000_0001;
            tick_reg <= 1'b0;
        end
    end
endmodule // ms_tick_gen

// *** verification/ctrl_source.sv ***
/* Far-side model: the selected control operand follows a press, the
 others carry noise. Assumes the bench changes inputs off the edge. */
`timescale 1ns/1ps
module ctrl_source (
    input wire press,
    input wire [3:0] sel,
    input wire [15:0] noise,
    output wire [15:0] operands
);
assign operands = (noise & ~(16'h0001 << sel)) | ({15'h0000, press} << sel);
endmodule // ctrl_source

// *** verification/lamp_check_properties.sv ***
/* Port assertions for the lamp check sequencer.
 Bound from the bench top; one clock domain. */
`timescale 1ns/1ps
module lamp_check_properties #(
    parameter LAMPS = 62
) (
    input wire clk_sys,
    input wire rst_n,
    input wire lamp_check_enable,
    input wire [LAMPS-1:0] lamp_request,
    input wire [LAMPS-1:0] lamp_out,
    input wire lamp_check_active_flag,
    input wire lamp_check_begun_event,
    input wire target_reset_out,
    input wire [1:0] stage_out
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_n);
a_begun_opens: assert property (lamp_check_begun_event |->
    lamp_check_active_flag && stage_out == 2'd1
    && !$past(lamp_check_active_flag)) else $error("event without start");
a_begun_once: assert property (lamp_check_begun_event |=>
    !lamp_check_begun_event) else $error("event longer than one cycle");
a_flag_stage: assert property (lamp_check_active_flag ==
    (stage_out != 2'd0)) else $error("flag and stage disagree");
a_all_lit: assert property ((stage_out == 2'd1) [*2] |->
    &lamp_out) else $error("stage one lamp dark");
a_walk_on: assert property ((stage_out == 2'd2) [*2] |->
    $onehot0(lamp_out)) else $error("stage two several lamps lit");
a_walk_off: assert property ((stage_out == 2'd3) [*2] |->
    $onehot0(~lamp_out)) else $error("stage three several lamps dark");
a_reset_held: assert property (lamp_check_active_flag
    && $past(lamp_check_active_flag) |-> !target_reset_out)
    else $error("target reset passed in test");
a_idle_follow: assert property (!lamp_check_active_flag
    && $past(!lamp_check_active_flag) |-> lamp_out == $past(lamp_request))
    else $error("idle lamps not following requests");
a_no_start_off: assert property ((!lamp_check_enable) [*3] |->
    !lamp_check_begun_event) else $error("start while disabled");
endmodule // lamp_check_properties

// *** verification/lamp_check_sequencer_tb_top.sv ***
/* Bench for the lamp check sequencer with a reference walk model.
 Short timing parameters: 4 clocks per ms; one 20 MHz clock. */
`timescale 1ns/1ps
module lamp_check_sequencer_tb_top;
localparam TK = 4;
reg clk_sys = 1'b0;
reg rst_n = 1'b0;
reg en = 1'b0;
reg press = 1'b0;
reg tgt = 1'b0;
reg [3:0] sel = 4'h0;
reg [15:0] noise = 16'h0000;
reg [61:0] req = 62'h0;
reg [31:0] seed = 32'h0000_002e;
wire [15:0] ops;
wire [61:0] lamps;
wire [1:0] stage;
wire flag;
wire begun;
wire tgt_out;
integer miscompares = 0;
integer n_compared = 0;
integer n_begun = 0;
integer k;
ctrl_source i_src (.press(press), .sel(sel), .noise(noise), .operands(ops));
lamp_check_sequencer #(.TICK_CYCLES(TK), .MIN_PULSE_MS(3),
    .STAGE1_MAX_MS(20), .STEP_MS(5)) i_dut (.clk_sys(clk_sys),
    .rst_n(rst_n), .lamp_check_enable(en), .lamp_check_trigger_select(sel),
    .control_operands(ops), .lamp_request(req), .target_reset_request(tgt),
    .lamp_out(lamps), .lamp_check_active_flag(flag),
    .lamp_check_begun_event(begun), .target_reset_out(tgt_out),
    .stage_out(stage));
initial begin
    forever #25 clk_sys = ~clk_sys;
end
always @(posedge clk_sys) begin
    if (begun === 1'b1)
        n_begun <= n_begun + 1;
end
function [31:0] rnd(input [31:0] s);
    reg [31:0] x;
    begin
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        rnd = x ^ (x << 5);
    end
endfunction
task roll;
    begin
        seed = rnd(seed);
        noise = seed[15:0];
        seed = rnd(seed);
        req = {req[29:0], seed};
    end
endtask
task give_verdict;
    begin
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
endtask
task chk(input [63:0] got, input [63:0] exp);
    begin
        n_compared = n_compared + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    end
endtask
task cyc(input integer n);
    begin
        repeat (n) @(negedge clk_sys);
    end
endtask
task wait_stage(input [1:0] s, input integer lim);
    integer i;
    begin
        i = 0;
        while (stage !== s && i < lim) begin
            cyc(1);
            i = i + 1;
        end
        chk(stage, s);
        if (stage !== s) begin
            miscompares = miscompares + 1;
            give_verdict;
        end
    end
endtask
task wait_lamps(input [61:0] e);
    integer i;
    begin
        i = 0;
        while (lamps !== e && i < 12 * TK) begin
            cyc(1);
            i = i + 1;
        end
        chk(lamps, e);
        if (lamps !== e) begin
            miscompares = miscompares + 1;
            give_verdict;
        end
    end
endtask
initial begin
    cyc(3);
    rst_n = 1'b1;
    cyc(2);
    roll;
    press = 1'b1;
    cyc(6 * TK);
    press = 1'b0;
    cyc(2 * TK);
    chk(n_begun, 0);
    en = 1'b1;
    press = 1'b1;
    cyc(TK);
    press = 1'b0;
    cyc(4 * TK);
    chk(n_begun, 0);
    $display("test 1 done");
    sel = seed[19:16];
    press = 1'b1;
    wait_stage(2'd1, 40 * TK);
    cyc(1);
    chk(n_begun, 1);
    chk(lamps, {62{1'b1}});
    tgt = 1'b1;
    cyc(3);
    chk(tgt_out, 0);
    tgt = 1'b0;
    roll;
    cyc(4 * TK);
    chk(flag, 1);
    press = 1'b0;
    for (k = 0; k < 62; k = k + 1) begin
        wait_lamps({61'h0, 1'b1} << k);
        if (k == 30)
            roll;
    end
    wait_stage(2'd3, 12 * TK);
    for (k = 0; k < 62; k = k + 1)
        wait_lamps(~({61'h0, 1'b1} << k));
    wait_stage(2'd0, 12 * TK);
    cyc(2);
    chk(lamps, req);
    $display("test 2 done");
    press = 1'b1;
    wait_stage(2'd1, 40 * TK);
    press = 1'b0;
    wait_stage(2'd2, 4 * TK);
    cyc(3 * TK);
    press = 1'b1;
    cyc(4 * TK);
    press = 1'b0;
    wait_stage(2'd0, 8 * TK);
    $display("test 3 done");
    cyc(2 * TK);
    press = 1'b1;
    wait_stage(2'd1, 40 * TK);
    cyc(15 * TK);
    chk(stage, 1);
    wait_stage(2'd0, 10 * TK);
    press = 1'b0;
    cyc(2 * TK);
    chk(stage, 0);
    chk(n_begun, 3);
    tgt = 1'b1;
    cyc(2);
    chk(tgt_out, 1);
    tgt = 1'b0;
    $display("test 4 done");
    give_verdict;
end
endmodule // lamp_check_sequencer_tb_top
bind lamp_check_sequencer lamp_check_properties #(.LAMPS(LAMPS)) i_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .lamp_check_enable(lamp_check_enable),
    .lamp_request(lamp_request), .lamp_out(lamp_out),
    .lamp_check_active_flag(lamp_check_active_flag),
    .lamp_check_begun_event(lamp_check_begun_event),
    .target_reset_out(target_reset_out), .stage_out(stage_out));
